// >>> hfi_pkg.sv
// package for the hdlc fifo and interrupt status block
// assumes a wishbone classic slave with 8-bit registers in the low data bits
package hfi_pkg;
    localparam int HFI_AW = 8;
    localparam logic [7:0] HFI_FIFO_LAST = 8'h1F;
    localparam logic [7:0] HFI_INTERRUPT_CAUSE_FLAGS_OFS = 8'h20;
    localparam logic [7:0] HFI_MASK_OFS = 8'h24;
    localparam logic [7:0] HFI_CMD_OFS = 8'h28;
    localparam logic [7:0] HFI_CONTROLLER_STATUS_OFS = 8'h2C;
    localparam logic [7:0] HFI_RECEIVE_COUNT_LOW_OFS = 8'h30;
    localparam logic [7:0] HFI_RECEIVE_COUNT_HIGH_OFS = 8'h34;
    localparam logic [7:0] HFI_RECEIVE_FRAME_STATUS_OFS = 8'h38;
    localparam logic [7:0] HFI_EXIR_OFS = 8'h3C;
    localparam logic [7:0] HFI_CIR_OFS = 8'h40;
    localparam logic [7:0] HFI_RST_VAL = 8'h00;
    // flag positions
    localparam int HFI_B_RME = 7;
    localparam int HFI_B_RPF = 6;
    localparam int HFI_B_RSC = 5;
    localparam int HFI_B_XPR = 4;
    localparam int HFI_B_TIN = 3;
    localparam int HFI_B_CHG = 2;
    localparam int HFI_B_SIN = 1;
    localparam int HFI_B_EXI = 0;
    // command bits
    localparam int HFI_C_RMC = 7;
    localparam int HFI_C_XTF = 3;
    localparam int HFI_C_XIF = 2;
    localparam int HFI_C_XME = 1;
    localparam int HFI_POOL = 32;
    typedef enum logic [1:0] {HFI_TX_IDLE, HFI_TX_SEND, HFI_TX_WAIT_END, HFI_TX_WAIT_ACK} hfi_tx_type;
endpackage

// >>> hfi_mem.sv
// small byte memory with registered read data
// assumes one write and one read port on one clock
`timescale 1ns/1ns
module hfi_mem #(
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic i_clk, // clock
    input wire logic i_we, // write strobe
    input wire logic [AW-1:0] i_waddr, // write address
    input wire logic [7:0] i_wdata, // write data
    input wire logic [AW-1:0] i_raddr, // read address
    output logic [7:0] o_rdata // registered read data
);
    logic [7:0] mem_q [DEPTH];
    initial begin
        if (DEPTH > (1 << AW)) $error("hfi_mem depth exceeds address range");
    end
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_q[i_raddr];
    end
endmodule

// >>> hfi_top.sv
// hdlc receive/transmit fifo windows and interrupt status, wishbone slave
// assumes the hdlc engine drives the event and data ports on i_clk
// Functional notes
// - reads at 0x00-0x1F return next receive byte; read pointer steps each read
// - writes at 0x00-0x1F while idle and not full store at transmit write pointer, which steps each such write
// - receive fifo holds thirty-two bytes of a frame
// - pool-full flag raised only with exactly thirty-two bytes waiting
// - after message end, low count register gives the low eight bits of the whole frame length
// - status register at 0x20, eight bits, read only, zero after reset
// - message end flag set when frame or its last part is stored
// - at message end, length in count registers, status in frame status
// - pool-full flag set per full 32-byte block of unfinished frame
// - auto mode: ready/not-ready change sets status change and remote bit
// - after send command, pool ready when pool emptied and frame unfinished
// - transparent frame with end: pool ready only after whole frame sent
// - auto info frame with end: pool ready after sent and acknowledged
// - status read clears all but extended and channel; those clear by cause reads
// - mask bit one hides a flag, which stays pending until unmasked
// - receive-done command after fetching releases the receive space
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
module hfi_top #(
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic i_clk, // 100 MHz clock
    input wire logic i_rst_b, // sync reset, active low
    input wire logic i_wb_cyc, // wishbone cycle
    input wire logic i_wb_stb, // wishbone strobe
    input wire logic i_wb_we, // wishbone write
    input wire logic [hfi_pkg::HFI_AW-1:0] i_wb_adr, // byte address
    input wire logic [3:0] i_wb_sel, // byte selects
    input wire logic [31:0] i_wb_dat, // write data
    output logic [31:0] o_wb_dat, // read data
    output logic o_wb_ack, // acknowledge
    output logic o_int, // interrupt level
    input wire logic i_auto_mode, // auto mode enable
    input wire logic i_rx_we, // receive byte strobe from hdlc engine
    input wire logic [7:0] i_rx_byte, // receive byte
    input wire logic i_rx_end, // frame end with last byte or alone
    input wire logic [7:0] i_rx_status, // frame status at end
    input wire logic i_rx_sframe, // supervisory frame seen
    input wire logic i_rx_rnr, // it was not-ready
    input wire logic i_tx_re, // engine takes one transmit byte
    input wire logic i_tx_done, // closing flag sent
    input wire logic i_tx_ack, // remote acknowledged info frame
    input wire logic i_timer_ev, // timer expired
    input wire logic i_chan_ev, // channel change
    input wire logic i_sync_ev, // sync transfer
    input wire logic i_ext_ev, // extended cause
    input wire logic [7:0] i_ext_cause, // extended cause value
    input wire logic [7:0] i_chan_val, // channel value
    output logic [7:0] o_tx_byte, // transmit byte to engine
    output logic o_tx_avail, // transmit bytes waiting
    output logic o_tx_last, // current block ends frame
    output logic o_rx_space // receive pool free for engine
);
    import hfi_pkg::*;
    initial begin
        if (DEPTH != HFI_POOL || (1 << AW) != DEPTH) $error("hfi_top needs 32 deep pool");
    end

    logic req, wr, rd, ack_q, pend_q;
    logic [7:0] adr;
    logic in_fifo, hit_interrupt_cause_flags, hit_mask, hit_cmd, hit_exir, hit_cir, mapped;
    assign adr = i_wb_adr;
    // one side effect per access: reads act at the edge before ack, writes at the ack edge
    assign req = i_wb_cyc && i_wb_stb;
    assign wr = req && ack_q && i_wb_we && i_wb_sel[0];
    assign rd = req && pend_q && !i_wb_we;
    assign in_fifo = adr <= HFI_FIFO_LAST;
    assign hit_interrupt_cause_flags = adr == HFI_INTERRUPT_CAUSE_FLAGS_OFS;
    assign hit_mask = adr == HFI_MASK_OFS;
    assign hit_cmd = adr == HFI_CMD_OFS;
    assign hit_exir = adr == HFI_EXIR_OFS;
    assign hit_cir = adr == HFI_CIR_OFS;
    assign mapped = in_fifo || hit_interrupt_cause_flags || hit_mask || hit_cmd || hit_exir || hit_cir ||
        adr == HFI_CONTROLLER_STATUS_OFS || adr == HFI_RECEIVE_COUNT_LOW_OFS || adr == HFI_RECEIVE_COUNT_HIGH_OFS ||
        adr == HFI_RECEIVE_FRAME_STATUS_OFS;

    // receive side
    logic [AW-1:0] rx_wp_q, rx_rp_q;
    logic [AW:0] rx_cnt_q;
    logic rx_busy_q;
    logic [7:0] rx_rdata;
    logic [11:0] msg_len_q;
    logic [7:0] receive_count_low_q, receive_frame_status_q;
    logic [3:0] receive_count_high_q;
    logic rx_take, rx_fifo_rd, rx_full_blk, receive_done_cmd;
    assign rx_take = i_rx_we && !rx_busy_q && rx_cnt_q < (AW+1)'(DEPTH);
    assign rx_fifo_rd = rd && in_fifo;
    assign rx_full_blk = rx_take && rx_cnt_q == (AW+1)'(DEPTH-1) && !i_rx_end;
    assign receive_done_cmd = wr && hit_cmd && i_wb_dat[HFI_C_RMC];

    hfi_mem #(.DEPTH(DEPTH), .AW(AW)) u_rx_mem (
        .i_clk(i_clk),
        .i_we(rx_take),
        .i_waddr(rx_wp_q),
        .i_wdata(i_rx_byte),
        .i_raddr(rx_rp_q),
        .o_rdata(rx_rdata)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rx_cnt_q <= '0;
            rx_busy_q <= 1'b0;
            msg_len_q <= '0;
            receive_count_low_q <= HFI_RST_VAL;
            receive_count_high_q <= '0;
            receive_frame_status_q <= HFI_RST_VAL;
        end else begin
            if (rx_take) begin
                rx_wp_q <= rx_wp_q + 1'b1;
                rx_cnt_q <= rx_cnt_q + 1'b1;
                msg_len_q <= i_rx_end ? '0 : msg_len_q + 1'b1;
            end
            if (rx_fifo_rd) begin
                rx_rp_q <= rx_rp_q + 1'b1;
            end
            if ((rx_full_blk || (i_rx_end && !rx_busy_q)) && !receive_done_cmd) begin
                rx_busy_q <= 1'b1; // pool held until the processor frees it
            end
            if (i_rx_end && !rx_busy_q) begin
                receive_count_low_q <= 8'(msg_len_q + {11'h000, rx_take});
                receive_count_high_q <= 4'((msg_len_q + {11'h000, rx_take}) >> 8);
                receive_frame_status_q <= i_rx_status;
            end
            if (receive_done_cmd && rx_busy_q) begin
                rx_busy_q <= 1'b0;
                rx_cnt_q <= '0;
                rx_wp_q <= '0;
                rx_rp_q <= '0;
            end
        end
    end

    // transmit side
    logic [AW-1:0] tx_wp_q, tx_rp_q;
    logic [AW:0] tx_cnt_q;
    logic tx_last_q, tx_ifr_q;
    hfi_tx_type tx_st_q;
    logic tx_fifo_wr, tx_go, tx_pop, tx_empty_ev, xpr_ev;
    logic [7:0] tx_rdata;
    assign tx_fifo_wr = wr && in_fifo && tx_st_q == HFI_TX_IDLE &&
        tx_cnt_q < (AW+1)'(DEPTH);
    assign tx_go = wr && hit_cmd && (i_wb_dat[HFI_C_XTF] ||
        (i_wb_dat[HFI_C_XIF] && i_auto_mode)) && tx_st_q == HFI_TX_IDLE;
    assign tx_pop = i_tx_re && tx_st_q == HFI_TX_SEND && tx_cnt_q != '0;
    assign tx_empty_ev = tx_pop && tx_cnt_q == (AW+1)'(1);
    assign xpr_ev = (tx_empty_ev && !tx_last_q) ||
        (tx_st_q == HFI_TX_WAIT_END && i_tx_done && !tx_ifr_q) ||
        (tx_st_q == HFI_TX_WAIT_ACK && i_tx_ack);

    hfi_mem #(.DEPTH(DEPTH), .AW(AW)) u_tx_mem (
        .i_clk(i_clk),
        .i_we(tx_fifo_wr),
        .i_waddr(tx_wp_q),
        .i_wdata(i_wb_dat[7:0]),
        .i_raddr(tx_pop ? tx_rp_q + 1'b1 : tx_rp_q),
        .o_rdata(tx_rdata)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            tx_cnt_q <= '0;
            tx_last_q <= 1'b0;
            tx_ifr_q <= 1'b0;
            tx_st_q <= HFI_TX_IDLE;
        end else begin
            if (tx_fifo_wr) begin
                tx_wp_q <= tx_wp_q + 1'b1;
                tx_cnt_q <= tx_cnt_q + 1'b1;
            end
            if (tx_pop) begin
                tx_rp_q <= tx_rp_q + 1'b1;
                tx_cnt_q <= tx_cnt_q - 1'b1;
            end
            unique case (tx_st_q)
                HFI_TX_IDLE: begin
                    if (tx_go) begin
                        tx_st_q <= HFI_TX_SEND;
                        tx_last_q <= i_wb_dat[HFI_C_XME];
                        tx_ifr_q <= !i_wb_dat[HFI_C_XTF];
                    end
                end
                HFI_TX_SEND: begin
                    if (tx_empty_ev) begin
                        tx_st_q <= tx_last_q ? HFI_TX_WAIT_END : HFI_TX_IDLE;
                        tx_wp_q <= '0;
                        tx_rp_q <= '0;
                    end
                end
                HFI_TX_WAIT_END: begin
                    if (i_tx_done) begin
                        tx_st_q <= tx_ifr_q ? HFI_TX_WAIT_ACK : HFI_TX_IDLE;
                    end
                end
                HFI_TX_WAIT_ACK: begin
                    if (i_tx_ack) begin
                        tx_st_q <= HFI_TX_IDLE;
                    end
                end
            endcase
        end
    end

    // interrupt flags, the set wins over a clearing read
    logic [7:0] interrupt_cause_flags_q, mask_q, ev, clr, shown, rdmux, interrupt_cause_flags_d, mask_d;
    logic remote_not_ready_bit_q, rsc_ev, rd_interrupt_cause_flags;
    logic [7:0] exir_q, cir_q;
    assign rd_interrupt_cause_flags = rd && hit_interrupt_cause_flags;
    assign rsc_ev = i_auto_mode && i_rx_sframe && (i_rx_rnr != remote_not_ready_bit_q);
    assign ev = {i_rx_end && !rx_busy_q, rx_full_blk, rsc_ev, xpr_ev,
        i_timer_ev, i_chan_ev, i_sync_ev, i_ext_ev};
    assign clr = {rd_interrupt_cause_flags ? 8'hFA : 8'h00} |
        {5'h00, rd && hit_cir, 1'b0, rd && hit_exir};
    assign shown = interrupt_cause_flags_q & ~mask_q;
    assign interrupt_cause_flags_d = (interrupt_cause_flags_q & ~(clr & ~mask_q)) | ev;
    assign mask_d = (wr && hit_mask) ? i_wb_dat[7:0] : mask_q;
    assign rdmux = in_fifo ? rx_rdata :
        hit_interrupt_cause_flags ? shown :
        hit_mask ? mask_q :
        adr == HFI_CONTROLLER_STATUS_OFS ? {4'h0, remote_not_ready_bit_q, 3'h0} :
        adr == HFI_RECEIVE_COUNT_LOW_OFS ? receive_count_low_q :
        adr == HFI_RECEIVE_COUNT_HIGH_OFS ? {4'h0, receive_count_high_q} :
        adr == HFI_RECEIVE_FRAME_STATUS_OFS ? receive_frame_status_q :
        hit_exir ? exir_q :
        hit_cir ? cir_q : 8'h00;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            interrupt_cause_flags_q <= HFI_RST_VAL;
            mask_q <= HFI_RST_VAL;
            remote_not_ready_bit_q <= 1'b0;
            exir_q <= HFI_RST_VAL;
            cir_q <= HFI_RST_VAL;
        end else begin
            interrupt_cause_flags_q <= interrupt_cause_flags_d;
            mask_q <= mask_d;
            if (rsc_ev) begin
                remote_not_ready_bit_q <= i_rx_rnr;
            end
            if (i_ext_ev) begin
                exir_q <= i_ext_cause;
            end
            if (i_chan_ev) begin
                cir_q <= i_chan_val;
            end
        end
    end

    // two wait states: fifo read data leaves the memory register in the ack cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pend_q <= 1'b0;
            ack_q <= 1'b0;
            o_wb_dat <= '0;
            o_int <= 1'b0;
            o_tx_byte <= '0;
            o_tx_avail <= 1'b0;
            o_tx_last <= 1'b0;
            o_rx_space <= 1'b1;
        end else begin
            pend_q <= i_wb_cyc && i_wb_stb && !ack_q && !pend_q;
            ack_q <= pend_q;
            o_wb_dat <= {24'h00_0000, (mapped ? rdmux : 8'h00)};
            // follows the flags and mask of the next cycle, so a masked leftover raises nothing
            o_int <= |(interrupt_cause_flags_d & ~mask_d);
            o_tx_byte <= tx_rdata;
            o_tx_avail <= tx_st_q == HFI_TX_SEND && tx_cnt_q > (AW+1)'(tx_pop);
            o_tx_last <= tx_last_q;
            o_rx_space <= !rx_busy_q;
        end
    end
    assign o_wb_ack = ack_q;

    // pool full only on a full block
    rpf_full_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        rx_full_blk |=> rx_cnt_q == (AW+1)'(DEPTH))
        else $error("pool full without 32 bytes");
    rme_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_rx_end && !rx_busy_q) |=> interrupt_cause_flags_q[HFI_B_RME])
        else $error("message end flag not set");
    rpf_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        rx_full_blk |=> interrupt_cause_flags_q[HFI_B_RPF] && rx_busy_q)
        else $error("pool full flag not set");
    sequence s_end_sent;
        tx_st_q == HFI_TX_WAIT_END && i_tx_done && !tx_ifr_q;
    endsequence
    xpr_end_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        s_end_sent |=> interrupt_cause_flags_q[HFI_B_XPR] && tx_st_q == HFI_TX_IDLE)
        else $error("ready flag missing after frame end");
    xpr_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (tx_st_q == HFI_TX_WAIT_ACK && !i_tx_ack) |-> !xpr_ev)
        else $error("ready flag before acknowledge");
    rx_ptr_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (rx_fifo_rd && !receive_done_cmd) |=> rx_rp_q == $past(rx_rp_q) + 1'b1)
        else $error("read pointer did not step");
    interrupt_cause_flags_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (rd_interrupt_cause_flags && ev == 8'h00) |=> (interrupt_cause_flags_q & 8'hFA & ~$past(mask_q)) == 8'h00)
        else $error("status read did not clear");
    mask_pend_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (interrupt_cause_flags_q[HFI_B_TIN] && mask_q[HFI_B_TIN]) |=> interrupt_cause_flags_q[HFI_B_TIN])
        else $error("masked flag lost");
    rmc_rel_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (receive_done_cmd && rx_busy_q) |=> !rx_busy_q ##1 o_rx_space)
        else $error("receive space not released");
endmodule

// >>> hfi_host.sv
// host processor model: wishbone classic master for the fifo windows and registers
// assumes the slave answers every request with a one-cycle ack
`timescale 1ns/1ns
module hfi_host (
    input wire logic i_clk, // clock
    input wire logic i_ack, // slave acknowledge
    input wire logic [31:0] i_dat, // slave read data
    output logic o_cyc, // cycle
    output logic o_stb, // strobe
    output logic o_we, // write enable
    output logic [7:0] o_adr, // byte address
    output logic [3:0] o_sel, // byte selects
    output logic [31:0] o_dat // write data
);
    initial begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_we = 1'b0;
        o_adr = 8'h00;
        o_sel = 4'h0;
        o_dat = 32'h0000_0000;
    end
    // entered just after a rising edge; leaves one idle cycle behind
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
            output logic [7:0] rd);
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we <= we;
        o_adr <= adr;
        o_sel <= 4'h1;
        o_dat <= {24'h00_0000, wd};
        @(posedge i_clk);
        while (i_ack !== 1'b1) @(posedge i_clk);
        rd = i_dat[7:0];
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        // released lines must not keep showing the old request
        o_adr <= ~adr;
        o_dat <= ~{24'h00_0000, wd};
        @(posedge i_clk);
    endtask
endmodule

// >>> hfi_top_test.sv
// self-checking bench for the hdlc fifo windows and interrupt status block
// assumes the host model drives wishbone while this bench plays the hdlc engine
`timescale 1ns/1ns
module hfi_top_test;
    import hfi_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic auto_m = 1'b0;
    logic rx_we = 1'b0;
    logic rx_rnr = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [7:0] rx_st = 8'h00;
    logic [7:0] cause = 8'h00;
    logic [8:0] evs = 9'h000;
    logic cyc, stb, we, ack, irq, tx_av, tx_last, rx_space;
    logic [7:0] adr, tx_byte, d;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [7:0] q[$];
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int ev_in[4] = '{5, 7, 6, 8};
    int ev_bit[4] = '{3, 1, 2, 0};
    logic [7:0] ev_src[4] = '{8'h00, 8'h00, 8'h40, 8'h3C};
    always #5 clk = ~clk;
    hfi_host host (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb),
        .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));
    hfi_top uut (.i_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .o_int(irq), .i_auto_mode(auto_m), .i_rx_we(rx_we),
        .i_rx_byte(rx_byte), .i_rx_end(evs[0]), .i_rx_status(rx_st),
        .i_rx_sframe(evs[1]), .i_rx_rnr(rx_rnr), .i_tx_re(evs[2]), .i_tx_done(evs[3]),
        .i_tx_ack(evs[4]), .i_timer_ev(evs[5]), .i_chan_ev(evs[6]), .i_sync_ev(evs[7]),
        .i_ext_ev(evs[8]), .i_ext_cause(cause), .i_chan_val(cause), .o_tx_byte(tx_byte),
        .o_tx_avail(tx_av), .o_tx_last(tx_last), .o_rx_space(rx_space));
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            finish_test();
        end
    end
    function automatic logic [7:0] flag(input int p);
        return 8'h01 << p;
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic irqc(input logic e);
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask
    task automatic rdm(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        host.xfer(1'b0, a, 8'h00, d);
        chk($sformatf("reg %h", a), e, d & m);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.xfer(1'b1, a, v, d);
    endtask
    // three idle cycles let the flag and the lagging interrupt settle
    task automatic pulse(input int k);
        evs[k] <= 1'b1;
        @(posedge clk);
        evs <= 9'h000;
        repeat (3) @(posedge clk);
    endtask
    task automatic rx(input int n, input bit last, input int total);
        q = {};
        rx_st <= 8'($urandom);
        for (int i = 0; i < n; i++) begin
            q.push_back(8'($urandom));
            rx_we <= 1'b1;
            rx_byte <= q[i];
            evs[0] <= last && i == n - 1;
            @(posedge clk);
            rx_we <= 1'b0;
            evs[0] <= 1'b0;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
        irqc(1'b1);
        rdm(8'h20, last ? flag(7) : flag(6), 8'hFF);
        rdm(8'h20, 8'h00, 8'hFF);
        if (last) begin
            rdm(8'h30, 8'(total), 8'hFF);
            rdm(8'h34, 8'(total >> 8), 8'h0F);
            rdm(8'h38, rx_st, 8'hFF);
        end
        foreach (q[i]) rdm(8'($urandom % 32), q[i], 8'hFF);
        chk("rx space", 8'h00, {7'h00, rx_space});
        wr(8'h28, flag(7));
        @(posedge clk);
        chk("rx space", 8'h01, {7'h00, rx_space});
    endtask
    task automatic tx(input int n, input logic [7:0] cmd, input bit need_ack);
        q = {};
        for (int i = 0; i < n; i++) begin
            q.push_back(8'($urandom));
            wr(8'($urandom % 32), q[i]);
        end
        wr(8'h28, cmd);
        foreach (q[i]) begin
            while (tx_av !== 1'b1) @(posedge clk);
            chk("tx byte", q[i], tx_byte);
            chk("tx last", {7'h00, cmd[1]}, {7'h00, tx_last});
            pulse(2);
        end
        irqc(!cmd[1]);
        if (cmd[1]) begin
            pulse(3);
            if (need_ack) begin
                irqc(1'b0);
                pulse(4);
            end
        end
        rdm(8'h20, flag(4), 8'hFF);
    endtask
    initial begin
        int n;
        void'($urandom(98929));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        irqc(1'b0);
        rdm(8'h20, 8'h00, 8'hFF);
        wr(8'h20, 8'hFF);
        rdm(8'h20, 8'h00, 8'hFF);
        rdm(8'h50, 8'h00, 8'hFF);
        n = 1 + $urandom % 32;
        rx(n, 1'b1, n);
        rx(32, 1'b0, 32);
        n = 1 + $urandom % 32;
        rx(n, 1'b1, 32 + n);
        foreach (ev_in[k]) begin
            cause <= 8'($urandom);
            pulse(ev_in[k]);
            irqc(1'b1);
            rdm(8'h20, flag(ev_bit[k]), 8'hFF);
            if (ev_src[k] != 8'h00) begin
                rdm(8'h20, flag(ev_bit[k]), 8'hFF);
                rdm(ev_src[k], cause, 8'hFF);
            end
            rdm(8'h20, 8'h00, 8'hFF);
            irqc(1'b0);
        end
        wr(8'h24, flag(3));
        pulse(5);
        irqc(1'b0);
        rdm(8'h20, 8'h00, 8'hFF);
        wr(8'h24, 8'h00);
        @(posedge clk);
        irqc(1'b1);
        rdm(8'h20, flag(3), 8'hFF);
        auto_m <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rx_rnr <= i < 2;
            pulse(1);
            rdm(8'h20, i == 1 ? 8'h00 : flag(5), 8'hFF);
            rdm(8'h2C, {4'h0, i < 2, 3'h0}, 8'h08);
        end
        tx(5, 8'h08, 1'b0);
        tx(32, 8'h0A, 1'b0);
        tx(1 + $urandom % 32, 8'h06, 1'b1);
        finish_test();
    end
endmodule
